/* logic/pmc_pkg.sv */
// constants shared by the power-mode controller and its bench
// assumes one 40 MHz clock and an APB master with 32-bit data
//
// Overview of operation
// RULE1: halt stops main, pll, core, peripheral, slow clocks
// RULE2: halt powers oscillator and plls off; slow optional
// RULE3: link sleep gates clocks in power save/idle
// RULE4: main gate enable covers oscillator and all plls
// RULE5: entering active clears all gate enables
// RULE6: disable bits force clocks off, beat gating
// RULE7: wake-up clears main and pll disable bits
// RULE8: halt off, active on, active restarts enabled plls
// RULE9: immediate switch only active to power save; code also goes power save to idle or halt at once when defer is off
// RULE10: deferred switch waits for wait instruction
// RULE11: software defers for idle or halt entry
// RULE12: wake from wake unit, nmi, optional ack
// RULE13: wake latched until interrupt ack or reset
// RULE14: wake returns active, cpu still waits
// RULE15: power-save bit read value follows defer mode
// RULE16: idle only from power save, with wait; code enters idle without wait when defer is off
// RULE17: main disable acts only inside power save/idle
// RULE18: software waits slow clock stable first
// RULE19: software keeps slow clock off main clock
// RULE20: halt only from active or power save
// RULE21: clearing power-save request returns to active
// RULE22: software re-enables oscillator before leaving
// RULE23: wake waits for needed clocks stable
// RULE24: switch held until needed clock stable
package pmc_pkg;

	// ------------------------------------------------------------
	// register map, byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] PMC_OFF_STCTL = 8'h00; // state control
	localparam logic [7:0] PMC_OFF_PLL1 = 8'h04; // pll run enables
	localparam logic [7:0] PMC_OFF_PLL2 = 8'h08; // pll gating
	localparam logic [7:0] PMC_OFF_STAT = 8'h0c; // status, read only

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int PMC_B_PSM = 0; // power_save_request
	localparam int PMC_B_IDLE = 1; // idle request
	localparam int PMC_B_HALT = 2; // halt request
	localparam int PMC_B_DEFER = 3; // defer_to_wait
	localparam int PMC_B_DMC = 4; // main_clock_disable
	localparam int PMC_B_HW_MAIN_CLOCK_GATE_EN = 5; // hw_main_clock_gate_en
	localparam int PMC_B_WAKE_ON_INT_ACK = 6; // wake_on_int_ack
	localparam int PMC_B_DSC = 7; // slow_osc_disable
	localparam int PMC_B_PLLDIS = 0; // pll_disable, two bits
	localparam int PMC_B_PLLHCC = 2; // hw_pll_gate_en, two bits
	localparam int PMC_B_PLLSTB = 4; // pll stable, two bits
	localparam int PMC_B_MSTB = 0; // main_clock_stable
	localparam int PMC_B_SSTB = 1; // slow_clock_stable
	localparam int PMC_B_MODE = 2; // mode, two bits
	localparam int PMC_B_WAKE = 4; // wake latched
	localparam int PMC_B_WAKING = 5; // waiting for clocks

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] PMC_RST_STCTL = 8'h00;
	localparam logic [1:0] PMC_RST_RUN = 2'h0;
	localparam logic [1:0] PMC_RST_PLL = 2'h0;

	// ------------------------------------------------------------
	// modes and states
	// ------------------------------------------------------------
	localparam logic [1:0] PMC_MODE_ACT = 2'h0;
	localparam logic [1:0] PMC_MODE_PS = 2'h1;
	localparam logic [1:0] PMC_MODE_IDLE = 2'h2;
	localparam logic [1:0] PMC_MODE_HALT = 2'h3;

	typedef enum logic [2:0] {
		PMC_ST_ACTIVE = 3'b000,
		PMC_ST_PSAVE = 3'b001,
		PMC_ST_IDLE = 3'b010,
		PMC_ST_HALT = 3'b011,
		PMC_ST_WAKE = 3'b100
	} pmc_state_e;

endpackage

/* logic/pmc_power_ctrl.sv */
// power-mode state machine with its apb register file
// assumes synchronous inputs and one clock; slow clock domain
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module pmc_power_ctrl
	import pmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic wait_i,
	input wire logic int_ack_i,
	input wire logic nmi_i,
	input wire logic multi_input_wakeup_wake_i,
	input wire logic llc_sleep_i,
	input wire logic main_clk_stable_i,
	input wire logic slow_clk_stable_i,
	input wire logic [1:0] pll_stable_i,
	input wire logic slow_from_main_i,
	output logic main_osc_en_o,
	output logic [1:0] pll_en_o,
	output logic hclk_en_o,
	output logic pclk_en_o,
	output logic slow_clk_en_o,
	output logic slow_osc_en_o,
	output logic [1:0] mode_o,
	output logic wake_latched_o
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// true in the two modes where gating and disables apply
	function automatic logic low_pw(input pmc_state_e s);
		low_pw = (s == PMC_ST_PSAVE) || (s == PMC_ST_IDLE);
	endfunction

	// every pll that is told to run reports stable
	function automatic logic plls_ok(input logic [1:0] run,
		input logic [1:0] stb);
		plls_ok = &(~run | stb);
	endfunction

	// ------------------------------------------------------------
	// reset and declarations
	// ------------------------------------------------------------
	logic rstn; // synchronised reset
	pmc_state_e state_r; // current mode
	pmc_state_e state_nxt;
	logic psm_r; // power-save request as written
	logic idle_r; // idle request
	logic halt_r; // halt request
	logic defer_r; // defer_to_wait
	logic dmc_r; // main_clock_disable
	logic hw_main_clock_gate_en_r; // hw_main_clock_gate_en
	logic wake_on_int_ack_r; // wake_on_int_ack
	logic dsc_r; // slow_osc_disable
	logic [1:0] run_en_r; // pll_run_enable
	logic [1:0] pll_dis_r; // pll_disable
	logic [1:0] hcc_pll_r; // hw_pll_gate_en
	logic wake_r; // latched wake-up
	logic wake_evt; // wake source this cycle
	logic to_active; // entering active this cycle
	logic acc; // access phase, answer edge
	logic wr_st; // write to state control
	logic wr_p1; // write to pll run enables
	logic wr_p2; // write to pll gating
	logic psm_rd; // power-save bit as read
	logic mapped; // address hits a register
	logic [31:0] rd_nxt;
	logic main_nxt;
	logic [1:0] pll_nxt;
	logic clk_ok; // clocks needed by active are stable

	pmc_rst_sync u_rst (
		.clk_i(clk_i),
		.ce_i(ce_i),
		.resetn_i(resetn_i),
		.rstn_o(rstn)
	);

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	// writes take effect on the edge where pready is seen high
	assign acc = psel_i && penable_i && pready_o && ce_i;
	assign wr_st = acc && pwrite_i && pstrb_i[0] &&
		(paddr_i == PMC_OFF_STCTL);
	assign wr_p1 = acc && pwrite_i && pstrb_i[0] &&
		(paddr_i == PMC_OFF_PLL1);
	assign wr_p2 = acc && pwrite_i && pstrb_i[0] &&
		(paddr_i == PMC_OFF_PLL2);
	assign mapped = (paddr_i == PMC_OFF_STCTL) ||
		(paddr_i == PMC_OFF_PLL1) || (paddr_i == PMC_OFF_PLL2) ||
		(paddr_i == PMC_OFF_STAT);

	// one wait state: pready rises one edge into the access phase
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			pready_o <= 1'b0;
		end else if (ce_i) begin
			pready_o <= psel_i && penable_i && !pready_o;
		end
	end

	// error flag for unmapped addresses and status writes
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			pslverr_o <= 1'b0;
		end else if (ce_i) begin
			pslverr_o <= psel_i && penable_i && !pready_o &&
				(!mapped || (pwrite_i && paddr_i == PMC_OFF_STAT));
		end
	end

	// ------------------------------------------------------------
	// wake-up detection
	// ------------------------------------------------------------
	// wake unit, nmi, or an ack when enabled
	assign wake_evt = multi_input_wakeup_wake_i || nmi_i || (wake_on_int_ack_r && int_ack_i); // RULE12

	// latched until an interrupt ack; a new event wins over the ack
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			wake_r <= 1'b0;
		end else if (ce_i) begin
			if (wake_evt) begin
				wake_r <= 1'b1; // RULE13
			end else if (int_ack_i) begin
				wake_r <= 1'b0; // RULE13
			end
		end
	end

	// ------------------------------------------------------------
	// mode state machine
	// ------------------------------------------------------------
	// active needs main, slow and every enabled pll stable
	assign clk_ok = main_clk_stable_i && slow_clk_stable_i &&
		plls_ok(run_en_r, pll_stable_i); // RULE23 RULE24
	assign to_active = (state_nxt == PMC_ST_ACTIVE) &&
		(state_r != PMC_ST_ACTIVE);

	// next mode from requests, wait and wake-up
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			PMC_ST_ACTIVE: begin
				if (defer_r) begin
					// deferred: only at a wait instruction
					if (wait_i && slow_clk_stable_i) begin // RULE10
						if (halt_r) begin
							state_nxt = PMC_ST_HALT; // RULE20
						end else if (psm_r) begin
							// idle from here is not allowed
							state_nxt = PMC_ST_PSAVE; // RULE16
						end
					end
				end else if (psm_r && slow_clk_stable_i) begin
					// immediate path: power save only
					state_nxt = PMC_ST_PSAVE; // RULE9 RULE24
				end
			end
			PMC_ST_PSAVE: begin
				if (wake_r) begin
					state_nxt = PMC_ST_WAKE; // RULE14
				end else if (halt_r && (!defer_r || wait_i)) begin
					state_nxt = PMC_ST_HALT; // RULE20
				end else if (idle_r && (!defer_r || wait_i)) begin
					state_nxt = PMC_ST_IDLE; // RULE16
				end else if (!psm_r && clk_ok) begin
					state_nxt = PMC_ST_ACTIVE; // RULE21
				end
			end
			PMC_ST_IDLE, PMC_ST_HALT: begin
				if (wake_r) begin
					state_nxt = PMC_ST_WAKE; // RULE14
				end
			end
			PMC_ST_WAKE: begin
				// stay until every needed clock is stable
				if (clk_ok) begin
					state_nxt = PMC_ST_ACTIVE; // RULE23
				end
			end
			default: begin
				state_nxt = PMC_ST_ACTIVE;
			end
		endcase
	end

	// mode register
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			state_r <= PMC_ST_ACTIVE;
		end else if (ce_i) begin
			state_r <= state_nxt;
		end
	end

	// ------------------------------------------------------------
	// state control register
	// ------------------------------------------------------------
	// mode requests: software writes, hardware clears on wake
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			psm_r <= PMC_RST_STCTL[PMC_B_PSM];
			idle_r <= PMC_RST_STCTL[PMC_B_IDLE];
			halt_r <= PMC_RST_STCTL[PMC_B_HALT];
		end else if (ce_i) begin
			if (state_r == PMC_ST_WAKE) begin
				// requests drop once the wake-up is under way
				psm_r <= 1'b0;
				idle_r <= 1'b0;
				halt_r <= 1'b0;
			end
			if (wr_st) begin
				psm_r <= pwdata_i[PMC_B_PSM];
				idle_r <= pwdata_i[PMC_B_IDLE];
				halt_r <= pwdata_i[PMC_B_HALT];
			end
		end
	end

	// plain configuration bits
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			defer_r <= PMC_RST_STCTL[PMC_B_DEFER];
			wake_on_int_ack_r <= PMC_RST_STCTL[PMC_B_WAKE_ON_INT_ACK];
		end else if (ce_i && wr_st) begin
			defer_r <= pwdata_i[PMC_B_DEFER];
			wake_on_int_ack_r <= pwdata_i[PMC_B_WAKE_ON_INT_ACK];
		end
	end

	// oscillator disables, cleared by a wake-up event
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			dmc_r <= PMC_RST_STCTL[PMC_B_DMC];
			dsc_r <= PMC_RST_STCTL[PMC_B_DSC];
		end else if (ce_i) begin
			if (wake_evt) begin
				dmc_r <= 1'b0; // RULE7
				dsc_r <= 1'b0; // RULE23
			end
			if (wr_st) begin
				dmc_r <= pwdata_i[PMC_B_DMC];
				dsc_r <= pwdata_i[PMC_B_DSC];
			end
		end
	end

	// main gating enable, cleared on entry to active
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			hw_main_clock_gate_en_r <= PMC_RST_STCTL[PMC_B_HW_MAIN_CLOCK_GATE_EN];
		end else if (ce_i) begin
			if (wr_st) begin
				hw_main_clock_gate_en_r <= pwdata_i[PMC_B_HW_MAIN_CLOCK_GATE_EN];
			end else if (to_active) begin
				hw_main_clock_gate_en_r <= 1'b0; // RULE5
			end
		end
	end

	// ------------------------------------------------------------
	// pll control registers
	// ------------------------------------------------------------
	// run enables, software only
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			run_en_r <= PMC_RST_RUN;
		end else if (ce_i && wr_p1) begin
			run_en_r <= pwdata_i[1:0];
		end
	end

	// per-pll disable and gating enables
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			pll_dis_r <= PMC_RST_PLL;
			hcc_pll_r <= PMC_RST_PLL;
		end else if (ce_i) begin
			if (wake_evt) begin
				pll_dis_r <= 2'h0; // RULE7
			end
			if (to_active) begin
				hcc_pll_r <= 2'h0; // RULE5
			end
			if (wr_p2) begin
				pll_dis_r <= pwdata_i[PMC_B_PLLDIS +: 2];
				hcc_pll_r <= pwdata_i[PMC_B_PLLHCC +: 2];
			end
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// reads one outside active; in active, deferred reads as written, immediate reads zero
	assign psm_rd = (state_r != PMC_ST_ACTIVE) ||
		(defer_r && psm_r); // RULE15 RULE21

	// read mux, unmapped reads give zero
	always_comb begin
		rd_nxt = 32'h0;
		unique case (paddr_i)
			PMC_OFF_STCTL: begin
				rd_nxt[PMC_B_PSM] = psm_rd;
				rd_nxt[PMC_B_IDLE] = idle_r;
				rd_nxt[PMC_B_HALT] = halt_r;
				rd_nxt[PMC_B_DEFER] = defer_r;
				rd_nxt[PMC_B_DMC] = dmc_r;
				rd_nxt[PMC_B_HW_MAIN_CLOCK_GATE_EN] = hw_main_clock_gate_en_r;
				rd_nxt[PMC_B_WAKE_ON_INT_ACK] = wake_on_int_ack_r;
				rd_nxt[PMC_B_DSC] = dsc_r;
			end
			PMC_OFF_PLL1: begin
				rd_nxt[1:0] = run_en_r;
			end
			PMC_OFF_PLL2: begin
				rd_nxt[PMC_B_PLLDIS +: 2] = pll_dis_r;
				rd_nxt[PMC_B_PLLHCC +: 2] = hcc_pll_r;
				rd_nxt[PMC_B_PLLSTB +: 2] = pll_stable_i;
			end
			PMC_OFF_STAT: begin
				rd_nxt[PMC_B_MSTB] = main_clk_stable_i;
				rd_nxt[PMC_B_SSTB] = slow_clk_stable_i;
				rd_nxt[PMC_B_MODE +: 2] = state_r[1:0];
				rd_nxt[PMC_B_WAKE] = wake_r;
				rd_nxt[PMC_B_WAKING] = (state_r == PMC_ST_WAKE);
			end
			default: begin
				rd_nxt = 32'h0;
			end
		endcase
	end

	// read data captured on the edge that raises pready
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			prdata_o <= 32'h0;
		end else if (ce_i && psel_i && penable_i && !pready_o) begin
			prdata_o <= pwrite_i ? 32'h0 : rd_nxt;
		end
	end

	// ------------------------------------------------------------
	// clock control
	// ------------------------------------------------------------
	// oscillator: on in active and wake, off in halt,
	// gated in power save and idle unless slow clock needs it
	// decoded from the next mode so enables change with mode_o
	always_comb begin
		main_nxt = 1'b1; // RULE8
		if (state_nxt == PMC_ST_HALT) begin
			main_nxt = 1'b0; // RULE2 RULE8
		end else if (low_pw(state_nxt) && !slow_from_main_i) begin
			// disable wins; gating only while the link sleeps
			if (dmc_r) begin
				main_nxt = 1'b0; // RULE6 RULE17
			end else if (hw_main_clock_gate_en_r && llc_sleep_i) begin
				main_nxt = 1'b0; // RULE3 RULE4
			end
		end
	end

	// plls follow their run enables and never outlive the oscillator
	always_comb begin
		pll_nxt = run_en_r & {2{main_nxt}}; // RULE4 RULE8
		if (low_pw(state_nxt)) begin
			pll_nxt = pll_nxt & ~pll_dis_r; // RULE6
			if (llc_sleep_i && !hw_main_clock_gate_en_r) begin
				pll_nxt = pll_nxt & ~hcc_pll_r; // RULE3
			end
		end
	end

	// registered clock enables
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			main_osc_en_o <= 1'b1;
			pll_en_o <= 2'h0;
		end else if (ce_i) begin
			main_osc_en_o <= main_nxt;
			pll_en_o <= pll_nxt;
		end
	end

	// core, peripheral and slow clock gates per mode
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			hclk_en_o <= 1'b1;
			pclk_en_o <= 1'b1;
			slow_clk_en_o <= 1'b1;
			slow_osc_en_o <= 1'b1;
		end else if (ce_i) begin
			// core stays held while waking; the cpu resumes on
			// the interrupt of the wake source
			hclk_en_o <= (state_nxt == PMC_ST_ACTIVE) ||
				(state_nxt == PMC_ST_PSAVE); // RULE1 RULE14
			pclk_en_o <= (state_nxt == PMC_ST_ACTIVE) ||
				(state_nxt == PMC_ST_PSAVE); // RULE1
			slow_clk_en_o <= (state_nxt != PMC_ST_HALT); // RULE1
			slow_osc_en_o <= !((state_nxt == PMC_ST_HALT) &&
				dsc_r); // RULE2
		end
	end

	// ------------------------------------------------------------
	// status outputs
	// ------------------------------------------------------------
	// visible mode and wake latch
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			mode_o <= PMC_MODE_ACT;
			wake_latched_o <= 1'b0;
		end else if (ce_i) begin
			unique case (state_nxt)
				PMC_ST_PSAVE: mode_o <= PMC_MODE_PS;
				PMC_ST_IDLE: mode_o <= PMC_MODE_IDLE;
				PMC_ST_HALT: mode_o <= PMC_MODE_HALT;
				default: mode_o <= PMC_MODE_ACT;
			endcase
			wake_latched_o <= wake_r;
		end
	end

endmodule

/* logic/pmc_rst_sync.sv */
// reset release synchroniser for the power-mode controller
// assumes an active-low asynchronous reset from outside
`timescale 1ns/1ps
module pmc_rst_sync (
	input wire logic clk_i,
	input wire logic ce_i,
	input wire logic resetn_i,
	output logic rstn_o
);
	// ------------------------------------------------------------
	// two-stage release
	// ------------------------------------------------------------
	logic meta_r; // first stage, read only by second stage

	// assert at once, release after two enabled edges
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_r <= 1'b0;
			rstn_o <= 1'b0;
		end else if (ce_i) begin
			meta_r <= 1'b1;
			rstn_o <= meta_r;
		end
	end
endmodule

/* testbench/pmc_clk_model.sv */
// oscillator and pll model: stable flags follow enables after a lag
// assumes enables come from the controller on the same clock
`timescale 1ns/1ps
module pmc_clk_model #(
	parameter int LAG = 4 // start-up cycles of each source
) (
	input wire logic clk_i,
	input wire logic osc_en_i,
	input wire logic [1:0] pll_en_i,
	input wire logic slow_en_i,
	output logic main_stb_o,
	output logic [1:0] pll_stb_o,
	output logic slow_stb_o
);
	int cm = 0; // main oscillator start count
	int cs = 0; // slow oscillator start count
	int cp [2] = '{0, 0}; // pll lock counts

	// a source drops its flag at once when stopped
	always @(posedge clk_i) begin
		cm <= osc_en_i ? (cm < LAG ? cm + 1 : cm) : 0;
		cs <= slow_en_i ? (cs < LAG ? cs + 1 : cs) : 0;
		for (int i = 0; i < 2; i++) begin
			// pll cannot lock without the oscillator
			cp[i] <= (pll_en_i[i] && main_stb_o) ?
				(cp[i] < LAG ? cp[i] + 1 : cp[i]) : 0;
		end
	end
	assign main_stb_o = (cm == LAG);
	assign slow_stb_o = (cs == LAG);
	assign pll_stb_o = {cp[1] == LAG, cp[0] == LAG};
endmodule

/* testbench/pmc_power_ctrl_bench.sv */
// self-checking bench for the power-mode controller
// assumes the clock model and the bound checker beside it
`timescale 1ns/1ps
module pmc_power_ctrl_bench;
	import pmc_pkg::*;
	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0;
	logic pwrite_i = 0, wait_i = 0, int_ack_i = 0, nmi_i = 0;
	logic multi_input_wakeup_wake_i = 0, llc_sleep_i = 0, sfm = 0, er;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic pready_o, pslverr_o, main_osc_en_o, hclk_en_o, pclk_en_o;
	logic slow_clk_en_o, slow_osc_en_o, wake_latched_o, mstb, sstb;
	logic [1:0] pll_en_o, mode_o, pstb;
	int n_mismatch = 0, comparisons = 0;

	always #12.5 clk_i = ~clk_i;

	pmc_power_ctrl u_pmc_power_ctrl (.clk_i, .resetn_i, .ce_i(1'b1),
		.psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.pstrb_i(4'hf), .prdata_o, .pready_o, .pslverr_o, .wait_i,
		.int_ack_i, .nmi_i, .multi_input_wakeup_wake_i, .llc_sleep_i,
		.main_clk_stable_i(mstb), .slow_clk_stable_i(sstb),
		.pll_stable_i(pstb), .slow_from_main_i(sfm), .main_osc_en_o,
		.pll_en_o, .hclk_en_o, .pclk_en_o, .slow_clk_en_o,
		.slow_osc_en_o, .mode_o, .wake_latched_o);
	pmc_clk_model u_pmc_clk_model (.clk_i, .osc_en_i(main_osc_en_o),
		.pll_en_i(pll_en_o), .slow_en_i(slow_osc_en_o),
		.main_stb_o(mstb), .pll_stb_o(pstb), .slow_stb_o(sstb));

	// ------------------------------------------------------------
	// reporting and bus tasks
	// ------------------------------------------------------------
	task conclude;
		$display("mismatches %0d comparisons %0d", n_mismatch,
			comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task fail(input string m);
		n_mismatch++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task chk(input logic [7:0] g, input logic [7:0] x);
		comparisons++;
		if (g !== x) fail($sformatf("got %h expected %h", g, x));
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// one apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= {24'h0, d};
		@(posedge clk_i);
		penable_i <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (pready_o !== 1'b1 && k < 20);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (k >= 20) begin
			fail("no ready");
			conclude;
		end
	endtask
	task rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
		apb(1'b0, a, 8'h00);
		chk(rd[7:0] & m, x);
	endtask
	// one-cycle pulse: 0 wait, 1 nmi, 2 wake unit, 3 int ack
	task ev(input int s);
		@(posedge clk_i);
		case (s)
			0: wait_i <= 1'b1;
			1: nmi_i <= 1'b1;
			2: multi_input_wakeup_wake_i <= 1'b1;
			default: int_ack_i <= 1'b1;
		endcase
		@(posedge clk_i);
		{wait_i, nmi_i, multi_input_wakeup_wake_i, int_ack_i} <= 4'h0;
	endtask
	// mode settled, core clock on only in active and power save
	task wmode(input logic [1:0] m);
		int k;
		k = 0;
		while (!(mode_o === m && hclk_en_o === (m < 2'h2)) && k < 80) begin
			@(posedge clk_i);
			k++;
		end
		chk({6'h0, mode_o}, {6'h0, m});
		if (k >= 80) begin
			fail("mode wait");
			conclude;
		end
	endtask
	// poll a status bit until set
	task wstb(input int b);
		int k;
		k = 0;
		do begin
			apb(1'b0, 8'h0c, 8'h00);
			k++;
		end while (rd[b] !== 1'b1 && k < 40);
		chk({7'h0, rd[b]}, 8'h01);
		if (rd[b] !== 1'b1) conclude;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task s_regs;
		rdm(8'h00, 8'hff, 8'h00);
		rdm(8'h04, 8'hff, 8'h00);
		apb(1'b0, 8'h10, 8'h00);
		chk({7'h0, er}, 8'h01);
		apb(1'b1, 8'h0c, 8'hff);
		chk({7'h0, er}, 8'h01);
		wstb(1);
	endtask
	task s_imm;
		apb(1'b1, 8'h00, 8'h01);
		wmode(PMC_MODE_PS);
		rdm(8'h00, 8'h01, 8'h01);
		apb(1'b1, 8'h00, 8'h00);
		wmode(PMC_MODE_ACT);
		rdm(8'h00, 8'h01, 8'h00);
	endtask
	task s_defer;
		apb(1'b1, 8'h00, 8'h09);
		rdm(8'h00, 8'h0f, 8'h09);
		chk({6'h0, mode_o}, 8'h00);
		ev(0);
		wmode(PMC_MODE_PS);
		apb(1'b1, 8'h00, 8'h0b);
		ev(0);
		wmode(PMC_MODE_IDLE);
		ev(1);
		wmode(PMC_MODE_ACT);
		chk({7'h0, wake_latched_o}, 8'h01);
		rdm(8'h00, 8'hff, 8'h08);
		ev(3);
		cyc(3);
		chk({7'h0, wake_latched_o}, 8'h00);
	endtask
	task s_noidle;
		apb(1'b1, 8'h00, 8'h0a);
		ev(0);
		cyc(5);
		chk({6'h0, mode_o}, 8'h00);
		apb(1'b1, 8'h00, 8'h00);
	endtask
	task s_halt;
		apb(1'b1, 8'h08, 8'h03);
		apb(1'b1, 8'h00, 8'h9c);
		ev(0);
		wmode(PMC_MODE_HALT);
		chk({main_osc_en_o, pll_en_o, pclk_en_o, slow_clk_en_o}, 8'h00);
		chk({7'h0, slow_osc_en_o}, 8'h00);
		ev(2);
		wmode(PMC_MODE_ACT);
		rdm(8'h00, 8'hff, 8'h08);
		rdm(8'h08, 8'h03, 8'h00);
		ev(3);
	endtask
	task s_hcc;
		apb(1'b1, 8'h04, 8'h03);
		cyc(12);
		chk({6'h0, pll_en_o}, 8'h03);
		apb(1'b1, 8'h08, 8'h0c);
		apb(1'b1, 8'h00, 8'h21);
		wmode(PMC_MODE_PS);
		llc_sleep_i <= 1'b1;
		cyc(3);
		chk({5'h0, main_osc_en_o, pll_en_o}, 8'h00);
		llc_sleep_i <= 1'b0;
		wstb(0);
		apb(1'b1, 8'h00, 8'h20);
		wmode(PMC_MODE_ACT);
		rdm(8'h00, 8'hff, 8'h00);
		rdm(8'h08, 8'h0c, 8'h00);
		cyc(12);
		chk({6'h0, pll_en_o}, 8'h03);
	endtask
	task s_dmc;
		apb(1'b1, 8'h00, 8'h01);
		wmode(PMC_MODE_PS);
		sfm <= 1'b1;
		apb(1'b1, 8'h00, 8'h11);
		cyc(2);
		chk({7'h0, main_osc_en_o}, 8'h01);
		sfm <= 1'b0;
		cyc(2);
		chk({7'h0, main_osc_en_o}, 8'h00);
		apb(1'b1, 8'h00, 8'h01);
		wstb(0);
		apb(1'b1, 8'h00, 8'h00);
		wmode(PMC_MODE_ACT);
	endtask
	task s_wake_on_int_ack;
		apb(1'b1, 8'h00, 8'h41);
		wmode(PMC_MODE_PS);
		ev(3);
		wmode(PMC_MODE_ACT);
		apb(1'b1, 8'h00, 8'h00);
		ev(3);
		cyc(3);
		chk({7'h0, wake_latched_o}, 8'h00);
	endtask

	// ------------------------------------------------------------
	// main sequence and hang guard
	// ------------------------------------------------------------
	initial begin
		cyc(5);
		resetn_i <= 1'b1;
		cyc(3);
		s_regs;
		s_imm;
		s_defer;
		s_noidle;
		s_halt;
		s_hcc;
		s_dmc;
		s_wake_on_int_ack;
		conclude;
	end
	initial begin
		cyc(20000);
		fail("run timeout");
		conclude;
	end
endmodule

/* testbench/pmc_power_ctrl_monitor.sv */
// checker for the power-mode controller, watching its ports only
// assumes one clock domain and the active-low reset input
`timescale 1ns/1ps
module pmc_monitor
	import pmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic int_ack_i,
	input wire logic nmi_i,
	input wire logic multi_input_wakeup_wake_i,
	input wire logic main_clk_stable_i,
	input wire logic slow_clk_stable_i,
	input wire logic main_osc_en_o,
	input wire logic [1:0] pll_en_o,
	input wire logic hclk_en_o,
	input wire logic pclk_en_o,
	input wire logic slow_clk_en_o,
	input wire logic slow_osc_en_o,
	input wire logic [1:0] mode_o,
	input wire logic wake_latched_o
);
	// ------------------------------------------------------------
	// clocking
	// ------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// ------------------------------------------------------------
	// clock gating by mode
	// ------------------------------------------------------------
	chk_halt_stops: assert property (mode_o == PMC_MODE_HALT |->
		!(main_osc_en_o | hclk_en_o | pclk_en_o | slow_clk_en_o)
		&& pll_en_o == 2'h0) else $error("clock left running in halt");
	chk_active_osc: assert property (mode_o == PMC_MODE_ACT |->
		main_osc_en_o) else $error("oscillator off in active");
	chk_slow_osc_off: assert property (!slow_osc_en_o |->
		mode_o == PMC_MODE_HALT) else $error("slow osc off outside halt");
	chk_pll_needs_osc: assert property (pll_en_o != 2'h0 |->
		main_osc_en_o) else $error("pll runs without oscillator");

	// ------------------------------------------------------------
	// legal transitions and clock readiness
	// ------------------------------------------------------------
	chk_idle_from_ps: assert property ($changed(mode_o) &&
		mode_o == PMC_MODE_IDLE |-> $past(mode_o) == PMC_MODE_PS)
		else $error("idle entered from wrong mode");
	chk_halt_source: assert property ($changed(mode_o) &&
		mode_o == PMC_MODE_HALT |-> $past(mode_o) != PMC_MODE_IDLE)
		else $error("halt entered from idle");
	chk_ps_slow_ok: assert property ($changed(mode_o) &&
		mode_o == PMC_MODE_PS |-> $past(slow_clk_stable_i))
		else $error("power save entered on unstable slow clock");
	chk_wake_clocks: assert property ($rose(hclk_en_o) &&
		mode_o == PMC_MODE_ACT |-> $past(main_clk_stable_i) &&
		$past(slow_clk_stable_i)) else $error("active before stable");

	// ------------------------------------------------------------
	// wake-up latch
	// ------------------------------------------------------------
	chk_wake_sets: assert property (nmi_i || multi_input_wakeup_wake_i |->
		##[1:2] wake_latched_o) else $error("wake not latched");
	chk_latch_holds: assert property ($fell(wake_latched_o) |->
		$past(int_ack_i, 2)) else $error("latch cleared without ack");
	chk_wake_return: assert property (wake_latched_o &&
		!hclk_en_o |-> ##[1:60] hclk_en_o &&
		mode_o == PMC_MODE_ACT) else $error("no return to active");
endmodule

bind pmc_power_ctrl pmc_monitor u_pmc_monitor (.clk_i, .resetn_i,
	.int_ack_i, .nmi_i, .multi_input_wakeup_wake_i, .main_clk_stable_i,
	.slow_clk_stable_i, .main_osc_en_o, .pll_en_o, .hclk_en_o,
	.pclk_en_o, .slow_clk_en_o, .slow_osc_en_o, .mode_o,
	.wake_latched_o);
